// file: design/tmr_pkg.sv
// constants and types for the timer 0/1 mode and control block
package tmr_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_TCTRL = 8'h88;
    localparam logic [7:0] IDX_TMODE = 8'h89;
    localparam logic [7:0] IDX_TL0 = 8'h8A;
    localparam logic [7:0] IDX_TL1 = 8'h8B;
    localparam logic [7:0] IDX_TH0 = 8'h8C;
    localparam logic [7:0] IDX_TH1 = 8'h8D;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h90;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h91;

    // reset values
    localparam logic [7:0] TCTRL_RST = 8'h00;
    localparam logic [7:0] TMODE_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [2:0] IRQ_RST = 3'h0;

    // timer_run_flag_control fields
    localparam int TC_T1_OVF = 7;
    localparam int TC_T1_RUN = 6;
    localparam int TC_T0_OVF = 5;
    localparam int TC_T0_RUN = 4;
    localparam int TC_IRQB_FLAG = 3;
    localparam int TC_IRQB_TRIG = 2;

    // timer_mode_config fields
    localparam int TM_T0_GATE = 3;
    localparam int TM_T0_CNT_SEL = 2;
    localparam int TM_T0_MODE_LSB = 0;

    // interrupt status and mask fields
    localparam int ST_T0_OVF = 0;
    localparam int ST_T1_OVF = 1;
    localparam int ST_IRQB = 2;

    // prescaler width in the prescaled mode
    localparam int PRESCALE_W = 5;

    typedef enum logic [1:0] {
        MODE_PRESCALE = 2'b00,
        MODE_CASCADE = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT = 2'b11
    } tmr_mode_e;

endpackage

// file: design/tmr_timer01_ctrl.sv
// timer 0/1 mode, run and flag control with an avalon-mm register slave
//
// Overview of operation
// - select bit picks count pin or clock
// - mode 00: high byte behind 5-bit prescaler
// - mode 01: bytes cascade into 16-bit counter
// - mode 10: low byte reloads from high byte
// - mode 11: split bytes, high uses timer 1 bits
// - timer 1 overflow sets flag except in mode 11, vector clears it
// - timer 1 counts while run bit set, and always in mode 11
// - timer 0 overflow sets flag, vector clears it
// - timer 0 counts only while run bit set, except its high byte in mode 11
// - irq b flag set by edge or level
// - edge flag cleared by vector; level follows pin
// - gate bit also needs irq a pin high
// - trigger bit set means falling edge detection
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none

module tmr_timer01_ctrl
    import tmr_pkg::*;
#(
    parameter int ADDR_W = 10
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // external pins
    input wire logic timer0_count_pin_i,
    input wire logic ext_irq_a_pin_i,
    input wire logic ext_irq_b_pin_i,
    // core vectoring acknowledges
    input wire logic vec_t0_ack_i,
    input wire logic vec_t1_ack_i,
    input wire logic vec_irq_b_ack_i,
    // interrupt
    output logic irq_o
);

    initial
    begin
        if (ADDR_W < 10)
            $error("ADDR_W must be at least 10");
    end

    typedef struct packed {
        logic [7:0] tctrl;
        logic [7:0] tmode;
        logic [7:0] tl0;
        logic [7:0] th0;
        logic [7:0] tl1;
        logic [7:0] th1;
        logic cnt_q;
        logic irqb_q;
        logic [2:0] stat;
        logic [2:0] mask;
        logic waitreq;
        logic [31:0] rdata;
        logic irq;
    } tmr_state_s;

    localparam tmr_state_s ST_RESET = '{
        tctrl: TCTRL_RST, tmode: TMODE_RST,
        tl0: DATA_RST, th0: DATA_RST, tl1: DATA_RST, th1: DATA_RST,
        cnt_q: 1'b0, irqb_q: 1'b0, stat: IRQ_RST, mask: IRQ_RST,
        waitreq: 1'b1, rdata: 32'h0000_0000, irq: 1'b0};

    tmr_state_s st;
    tmr_state_s next_st;

    // byte increment, carry in bit 8
    function automatic logic [8:0] inc8(input logic [7:0] v);
        inc8 = {1'b0, v} + 9'h001;
    endfunction

    logic [7:0] idx;
    logic aligned;
    logic wr_fire;
    logic rd_fire;
    logic wr_lo;
    tmr_mode_e mode0;
    logic t0_en;
    logic cnt_fall;
    logic irqb_fall;
    logic t0_tick;

    assign idx = avs_address_i[9:2];
    assign aligned = (avs_address_i[1:0] == 2'b00)
        && ((avs_address_i >> 10) == '0);
    // access completes only at the edge where waitrequest is low
    assign wr_fire = avs_write_i && !st.waitreq && aligned;
    assign rd_fire = avs_read_i && !st.waitreq && aligned;
    assign wr_lo = wr_fire && avs_byteenable_i[0];
    assign mode0 = tmr_mode_e'(st.tmode[TM_T0_MODE_LSB +: 2]);
    // gated run: run bit, and irq a pin high when gate bit set
    assign t0_en = st.tctrl[TC_T0_RUN]
        && (!st.tmode[TM_T0_GATE] || ext_irq_a_pin_i);
    // one sample per machine cycle; single-cycle core so every clock
    assign cnt_fall = st.cnt_q && !timer0_count_pin_i;
    assign irqb_fall = st.irqb_q && !ext_irq_b_pin_i;
    assign t0_tick = t0_en
        && (st.tmode[TM_T0_CNT_SEL] ? cnt_fall : 1'b1);

    always_comb
    begin
        logic [8:0] s_lo;
        logic [8:0] s_hi;
        logic [5:0] s_pre;
        logic t0_ovf;
        logic t1_ovf;
        logic t1_en;
        logic irqb_set;
        next_st = st;
        s_lo = 9'h000;
        s_hi = 9'h000;
        s_pre = 6'h00;
        t0_ovf = 1'b0;
        t1_ovf = 1'b0;
        t1_en = 1'b0;
        irqb_set = 1'b0;
        next_st.cnt_q = timer0_count_pin_i;
        next_st.irqb_q = ext_irq_b_pin_i;

        // timer 0 counting
        case (mode0)
            MODE_PRESCALE:
            begin
                if (t0_tick)
                begin
                    s_pre = {1'b0, st.tl0[PRESCALE_W-1:0]} + 6'h01;
                    next_st.tl0[PRESCALE_W-1:0] = s_pre[PRESCALE_W-1:0];
                    if (s_pre[PRESCALE_W])
                    begin
                        s_hi = inc8(st.th0);
                        next_st.th0 = s_hi[7:0];
                        t0_ovf = s_hi[8];
                    end
                end
            end
            MODE_CASCADE:
            begin
                if (t0_tick)
                begin
                    s_lo = inc8(st.tl0);
                    next_st.tl0 = s_lo[7:0];
                    if (s_lo[8])
                    begin
                        s_hi = inc8(st.th0);
                        next_st.th0 = s_hi[7:0];
                        t0_ovf = s_hi[8];
                    end
                end
            end
            MODE_RELOAD:
            begin
                if (t0_tick)
                begin
                    s_lo = inc8(st.tl0);
                    next_st.tl0 = s_lo[8] ? st.th0 : s_lo[7:0];
                    t0_ovf = s_lo[8];
                end
            end
            MODE_SPLIT:
            begin
                if (t0_tick)
                begin
                    s_lo = inc8(st.tl0);
                    next_st.tl0 = s_lo[7:0];
                    t0_ovf = s_lo[8];
                end
                // high byte counts clocks on the timer 1 run bit
                if (st.tctrl[TC_T1_RUN])
                begin
                    s_hi = inc8(st.th0);
                    next_st.th0 = s_hi[7:0];
                    t1_ovf = s_hi[8];
                end
            end
            default: next_st.tl0 = st.tl0;
        endcase

        // timer 1: fixed 16-bit clock count; keeps running without its
        // flag while timer 0 is split, so it stays usable as a tick source
        t1_en = (mode0 == MODE_SPLIT) || st.tctrl[TC_T1_RUN];
        if (t1_en)
        begin
            s_lo = inc8(st.tl1);
            next_st.tl1 = s_lo[7:0];
            if (s_lo[8])
            begin
                s_hi = inc8(st.th1);
                next_st.th1 = s_hi[7:0];
                if (mode0 != MODE_SPLIT)
                    t1_ovf = s_hi[8];
            end
        end

        // software writes win over counting
        if (wr_lo)
        begin
            case (idx)
                IDX_TCTRL: next_st.tctrl = avs_writedata_i[7:0];
                IDX_TMODE: next_st.tmode = avs_writedata_i[7:0];
                IDX_TL0: next_st.tl0 = avs_writedata_i[7:0];
                IDX_TH0: next_st.th0 = avs_writedata_i[7:0];
                IDX_TL1: next_st.tl1 = avs_writedata_i[7:0];
                IDX_TH1: next_st.th1 = avs_writedata_i[7:0];
                IDX_IRQ_MASK: next_st.mask = avs_writedata_i[2:0];
                default: next_st.mask = next_st.mask;
            endcase
        end

        // overflow flags: vector clears, a same-cycle overflow wins
        if (vec_t0_ack_i)
            next_st.tctrl[TC_T0_OVF] = 1'b0;
        if (t0_ovf)
            next_st.tctrl[TC_T0_OVF] = 1'b1;
        if (vec_t1_ack_i)
            next_st.tctrl[TC_T1_OVF] = 1'b0;
        if (t1_ovf)
            next_st.tctrl[TC_T1_OVF] = 1'b1;

        // irq b request flag
        if (st.tctrl[TC_IRQB_TRIG])
        begin
            if (vec_irq_b_ack_i)
                next_st.tctrl[TC_IRQB_FLAG] = 1'b0;
            if (irqb_fall)
            begin
                next_st.tctrl[TC_IRQB_FLAG] = 1'b1;
                irqb_set = 1'b1;
            end
        end
        else
        begin
            // level mode: the source owns the flag, no latching
            next_st.tctrl[TC_IRQB_FLAG] = !ext_irq_b_pin_i;
            irqb_set = !ext_irq_b_pin_i && !st.tctrl[TC_IRQB_FLAG];
        end

        // sticky status: read clears only the bits it reported, so an
        // event landing during the wait cycle is not lost
        if (rd_fire && idx == IDX_IRQ_STAT)
            next_st.stat = st.stat & ~st.rdata[2:0];
        if (t0_ovf)
            next_st.stat[ST_T0_OVF] = 1'b1;
        if (t1_ovf)
            next_st.stat[ST_T1_OVF] = 1'b1;
        if (irqb_set)
            next_st.stat[ST_IRQB] = 1'b1;
        next_st.irq = |(next_st.stat & next_st.mask);

        // one wait cycle per access; data loaded as waitrequest drops
        next_st.waitreq = !((avs_read_i || avs_write_i) && st.waitreq);
        if (avs_read_i && st.waitreq)
        begin
            next_st.rdata = 32'h0000_0000;
            if (aligned)
            begin
                case (idx)
                    IDX_TCTRL: next_st.rdata[7:0] = st.tctrl;
                    IDX_TMODE: next_st.rdata[7:0] = st.tmode;
                    IDX_TL0: next_st.rdata[7:0] = st.tl0;
                    IDX_TH0: next_st.rdata[7:0] = st.th0;
                    IDX_TL1: next_st.rdata[7:0] = st.tl1;
                    IDX_TH1: next_st.rdata[7:0] = st.th1;
                    IDX_IRQ_STAT: next_st.rdata[2:0] = st.stat;
                    IDX_IRQ_MASK: next_st.rdata[2:0] = st.mask;
                    default: next_st.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            st <= ST_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign avs_readdata_o = st.rdata;
    assign avs_waitrequest_o = st.waitreq;
    assign irq_o = st.irq;

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    logic no_wr_t0;
    assign no_wr_t0 = !(wr_lo && (idx == IDX_TL0 || idx == IDX_TH0
        || idx == IDX_TMODE || idx == IDX_TCTRL));

    a_timer_clock_src: assert property (
        (mode0 == MODE_CASCADE && !st.tmode[TM_T0_CNT_SEL] && t0_en
         && no_wr_t0)
        |=> st.tl0 == $past(st.tl0) + 8'h01)
        else $error("timer 0 did not count a clock");

    a_count_pin_edge: assert property (
        (mode0 == MODE_CASCADE && st.tmode[TM_T0_CNT_SEL] && !cnt_fall
         && no_wr_t0)
        |=> $stable(st.tl0))
        else $error("timer 0 counted without a pin fall");

    a_run_gate_hold: assert property (
        (!t0_en && no_wr_t0) |=> $stable(st.tl0) && $stable(st.th0)
        || $past(mode0) == MODE_SPLIT)
        else $error("timer 0 counted while disabled");

    a_prescale_hold: assert property (
        (mode0 == MODE_PRESCALE && st.tl0[4:0] != 5'h1F && no_wr_t0)
        |=> $stable(st.th0))
        else $error("high byte moved before prescaler wrap");

    a_reload_value: assert property (
        (mode0 == MODE_RELOAD && t0_tick && st.tl0 == 8'hFF && no_wr_t0)
        |=> st.tl0 == $past(st.th0) && st.tctrl[TC_T0_OVF])
        else $error("reload or flag missing");

    a_t0_ovf_flag: assert property (
        (mode0 == MODE_CASCADE && t0_tick && st.tl0 == 8'hFF
         && st.th0 == 8'hFF && no_wr_t0)
        |=> st.tctrl[TC_T0_OVF] && st.stat[ST_T0_OVF])
        else $error("timer 0 overflow flag not set");

    a_split_high_flag: assert property (
        (mode0 == MODE_SPLIT && st.tctrl[TC_T1_RUN] && st.th0 == 8'hFF
         && no_wr_t0)
        |=> st.tctrl[TC_T1_OVF] && st.th0 == 8'h00)
        else $error("split high byte overflow lost");

    a_t1_stopped: assert property (
        (mode0 != MODE_SPLIT && !st.tctrl[TC_T1_RUN] && !wr_fire)
        |=> $stable(st.tl1) && $stable(st.th1))
        else $error("timer 1 counted while stopped");

    a_irqb_level: assert property (
        (!st.tctrl[TC_IRQB_TRIG])
        |=> st.tctrl[TC_IRQB_FLAG] == !$past(ext_irq_b_pin_i)
        || $past(wr_lo))
        else $error("level flag does not follow pin");

    a_irqb_edge: assert property (
        (st.tctrl[TC_IRQB_TRIG] && irqb_fall) |=> st.tctrl[TC_IRQB_FLAG])
        else $error("falling edge not latched");

    a_bus_one_wait: assert property (
        ((avs_read_i || avs_write_i) && st.waitreq) |=> !st.waitreq ##1
        st.waitreq)
        else $error("waitrequest not one cycle");

    c_split_mode: cover property (mode0 == MODE_SPLIT && t0_tick);
    c_reload_wrap: cover property (mode0 == MODE_RELOAD && t0_tick
        && st.tl0 == 8'hFF);
    c_edge_irq: cover property (st.tctrl[TC_IRQB_TRIG] && irqb_fall);
    c_irq_out: cover property (!st.irq ##1 st.irq);

endmodule

`default_nettype wire

// file: testbench/tmr_pin_model.sv
// model of the count pin and the two external interrupt pins
`timescale 1ns/1ns
`default_nettype none

module tmr_pin_model
(
    // clock
    input wire logic clk_i,
    // pins, idle high
    output logic count_pin_o,
    output logic irq_a_pin_o,
    output logic irq_b_pin_o
);
    initial
    begin
        count_pin_o = 1'b1;
        irq_a_pin_o = 1'b1;
        irq_b_pin_o = 1'b1;
    end

    // each level held two cycles so that no sample can miss it
    task automatic count_falls(input int n);
        repeat (n)
        begin
            count_pin_o <= 1'b0;
            repeat (2) @(posedge clk_i);
            count_pin_o <= 1'b1;
            repeat (2) @(posedge clk_i);
        end
    endtask

    task automatic set_pins(input logic a, input logic b);
        irq_a_pin_o <= a;
        irq_b_pin_o <= b;
        repeat (3) @(posedge clk_i);
    endtask
endmodule

`default_nettype wire

// file: testbench/tmr_timer01_ctrl_tb_top.sv
// self-checking bench for the timer 0/1 mode and control block
`timescale 1ns/1ns
`default_nettype none

module tmr_timer01_ctrl_tb_top import tmr_pkg::*;;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [9:0] avs_address_i = '0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = '0;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic cnt_pin;
    logic irq_a_pin;
    logic irq_b_pin;
    logic ack_t0 = 1'b0;
    logic ack_t1 = 1'b0;
    logic ack_b = 1'b0;
    logic irq_o;
    int mismatches = 0;
    int checks_done = 0;
    logic [31:0] rd;

    always #10 clk_i = ~clk_i;

    tmr_timer01_ctrl #(.ADDR_W(10)) i_dut (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .timer0_count_pin_i(cnt_pin),
        .ext_irq_a_pin_i(irq_a_pin),
        .ext_irq_b_pin_i(irq_b_pin),
        .vec_t0_ack_i(ack_t0),
        .vec_t1_ack_i(ack_t1),
        .vec_irq_b_ack_i(ack_b),
        .irq_o(irq_o)
    );

    tmr_pin_model i_pins (
        .clk_i(clk_i),
        .count_pin_o(cnt_pin),
        .irq_a_pin_o(irq_a_pin),
        .irq_b_pin_o(irq_b_pin)
    );

    task automatic print_verdict();
        if (mismatches == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic xfer(input logic wr, input logic [7:0] idx,
        input logic [7:0] wd);
        avs_address_i <= {idx, 2'b00};
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= {24'h0, wd};
        // only the watchdog ends a wait that never gets an answer
        do
            @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        xfer(1'b1, idx, wd);
    endtask

    task automatic chk(input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        cmp(rd, {24'h0, exp});
    endtask

    // irq_o is registered, so look after one more edge has landed
    task automatic chk_irq(input logic exp);
        @(posedge clk_i);
        @(negedge clk_i);
        cmp({31'h0, irq_o}, {31'h0, exp});
        @(posedge clk_i);
    endtask

    task automatic vec(input int which);
        ack_t0 <= (which == 0);
        ack_t1 <= (which == 1);
        ack_b <= (which == 2);
        @(posedge clk_i);
        ack_t0 <= 1'b0;
        ack_t1 <= 1'b0;
        ack_b <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic t_reset();
        chk(IDX_TCTRL, 8'h00);
        chk(IDX_TMODE, 8'h00);
        chk(IDX_TL0, 8'h00);
        chk(IDX_TH0, 8'h00);
        chk(IDX_IRQ_STAT, 8'h00);
        chk(IDX_IRQ_MASK, 8'h00);
        chk(8'h95, 8'h00);
        chk(IDX_TL1, 8'h00);
        chk(IDX_TH1, 8'h00);
        // a write without lane 0 enabled must leave the byte alone
        avs_byteenable_i <= 4'hE;
        wr(IDX_TL0, 8'h55);
        avs_byteenable_i <= 4'hF;
        chk(IDX_TL0, 8'h00);
    endtask

    task automatic t_cascade();
        wr(IDX_TMODE, 8'h05);
        wr(IDX_TL0, 8'hFE);
        wr(IDX_TH0, 8'hFF);
        wr(IDX_TCTRL, 8'h10);
        i_pins.count_falls(3);
        chk(IDX_TL0, 8'h01);
        chk(IDX_TH0, 8'h00);
        chk(IDX_TCTRL, 8'h30);
        vec(0);
        chk(IDX_TCTRL, 8'h10);
        wr(IDX_TCTRL, 8'h00);
        i_pins.count_falls(2);
        chk(IDX_TL0, 8'h01);
    endtask

    task automatic t_prescale();
        wr(IDX_TMODE, 8'h04);
        wr(IDX_TL0, 8'hFE);
        wr(IDX_TH0, 8'h05);
        wr(IDX_TCTRL, 8'h10);
        i_pins.count_falls(2);
        wr(IDX_TCTRL, 8'h00);
        chk(IDX_TL0, 8'hE0);
        chk(IDX_TH0, 8'h06);
    endtask

    task automatic t_reload();
        wr(IDX_TMODE, 8'h06);
        wr(IDX_TH0, 8'h80);
        wr(IDX_TL0, 8'hFF);
        wr(IDX_TCTRL, 8'h10);
        i_pins.count_falls(2);
        chk(IDX_TCTRL, 8'h30);
        wr(IDX_TCTRL, 8'h00);
        chk(IDX_TL0, 8'h81);
        chk(IDX_TH0, 8'h80);
    endtask

    task automatic t_split();
        wr(IDX_TMODE, 8'h07);
        wr(IDX_TH0, 8'hFF);
        wr(IDX_TL0, 8'hFF);
        wr(IDX_TCTRL, 8'h40);
        chk(IDX_TCTRL, 8'hC0);
        vec(1);
        chk(IDX_TCTRL, 8'h40);
        wr(IDX_TCTRL, 8'h00);
        wr(IDX_TH0, 8'hFF);
        wr(IDX_TCTRL, 8'h10);
        i_pins.count_falls(1);
        chk(IDX_TCTRL, 8'h30);
        chk(IDX_TH0, 8'hFF);
        wr(IDX_TCTRL, 8'h00);
    endtask

    task automatic t_timer1();
        logic [7:0] cnt;
        wr(IDX_TMODE, 8'h01);
        wr(IDX_TH1, 8'hFF);
        wr(IDX_TL1, 8'hFF);
        xfer(1'b0, IDX_IRQ_STAT, 8'h00);
        wr(IDX_TCTRL, 8'h40);
        chk(IDX_TCTRL, 8'hC0);
        chk(IDX_IRQ_STAT, 8'h02);
        chk(IDX_TH1, 8'h00);
        wr(IDX_TCTRL, 8'h00);
        xfer(1'b0, IDX_TL1, 8'h00);
        cnt = rd[7:0];
        cmp({31'h0, cnt inside {[8'h01:8'h20]}}, 32'h1);
        chk(IDX_TL1, cnt);
        chk(IDX_TH1, 8'h00);
    endtask

    task automatic t_midreset();
        wr(IDX_TL1, 8'hA5);
        wr(IDX_TMODE, 8'h0D);
        wr(IDX_IRQ_MASK, 8'h07);
        chk_irq(1'b1);
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        chk_irq(1'b0);
        chk(IDX_TL1, 8'h00);
        chk(IDX_TMODE, 8'h00);
        chk(IDX_IRQ_MASK, 8'h00);
        chk(IDX_IRQ_STAT, 8'h00);
    endtask

    task automatic t_timer();
        logic [7:0] first;
        wr(IDX_TMODE, 8'h01);
        wr(IDX_TL0, 8'h00);
        wr(IDX_TH0, 8'h00);
        wr(IDX_TCTRL, 8'h10);
        wr(IDX_TCTRL, 8'h00);
        xfer(1'b0, IDX_TL0, 8'h00);
        first = rd[7:0];
        cmp({31'h0, first inside {[8'h01:8'h08]}}, 32'h1);
        chk(IDX_TL0, first);
    endtask

    task automatic t_gate();
        wr(IDX_TMODE, 8'h0D);
        wr(IDX_TL0, 8'h00);
        i_pins.set_pins(1'b0, 1'b1);
        wr(IDX_TCTRL, 8'h10);
        i_pins.count_falls(2);
        chk(IDX_TL0, 8'h00);
        i_pins.set_pins(1'b1, 1'b1);
        i_pins.count_falls(2);
        chk(IDX_TL0, 8'h02);
        wr(IDX_TCTRL, 8'h00);
    endtask

    task automatic t_irq_edge();
        wr(IDX_TCTRL, 8'h04);
        xfer(1'b0, IDX_IRQ_STAT, 8'h00);
        i_pins.set_pins(1'b1, 1'b0);
        i_pins.set_pins(1'b1, 1'b1);
        chk(IDX_TCTRL, 8'h0C);
        chk_irq(1'b0);
        wr(IDX_IRQ_MASK, 8'h04);
        chk_irq(1'b1);
        chk(IDX_IRQ_STAT, 8'h04);
        chk_irq(1'b0);
        chk(IDX_IRQ_STAT, 8'h00);
        vec(2);
        chk(IDX_TCTRL, 8'h04);
    endtask

    task automatic t_irq_level();
        wr(IDX_TCTRL, 8'h00);
        i_pins.set_pins(1'b1, 1'b0);
        chk(IDX_TCTRL, 8'h08);
        vec(2);
        chk(IDX_TCTRL, 8'h08);
        i_pins.set_pins(1'b1, 1'b1);
        chk(IDX_TCTRL, 8'h00);
    endtask

    initial
    begin
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_cascade();
        t_prescale();
        t_reload();
        t_split();
        t_timer1();
        t_timer();
        t_gate();
        t_irq_edge();
        t_irq_level();
        t_midreset();
        print_verdict();
    end

    // whole run needs well under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        $display("unexpected at %0t: run did not finish", $time);
        print_verdict();
    end
endmodule

`default_nettype wire
